// ### logic/crl_pkg.sv
// Purpose: Shared constants and types of the card rights and reuse lockout block
// Assumes: 125 MHz clock, 32-bit register port, 32-bit card codes
// Notes: Register offsets are word indices on the plain register port
package crl_pkg;
  localparam int CRL_CLK_HZ = 125_000_000;
  localparam int CRL_SEC_S = 1;
  localparam int CRL_SEC_PER_MIN = 60;
  localparam int CRL_PROG_TIMEOUT_S = 15;
  localparam int CRL_ERASE_READS = 5;
  localparam int CRL_ID_W = 32;
  localparam int CRL_DATE_W = 16;
  localparam int CRL_TMR_W = 8;
  localparam int CRL_CODE_W = 4;
  localparam int CRL_IDX_W = 8;
  localparam int CRL_AW = 4;
  localparam int CRL_DW = 32;
  localparam logic [CRL_AW-1:0] CRL_A_CTRL = 4'h0;
  localparam logic [CRL_AW-1:0] CRL_A_LOCK_INIT = 4'h1;
  localparam logic [CRL_AW-1:0] CRL_A_ALARM_SECS = 4'h2;
  localparam logic [CRL_AW-1:0] CRL_A_DATE = 4'h3;
  localparam logic [CRL_AW-1:0] CRL_A_INS_CARD = 4'h4;
  localparam logic [CRL_AW-1:0] CRL_A_DEL_CARD = 4'h5;
  localparam logic [CRL_AW-1:0] CRL_A_DL_INDEX = 4'h6;
  localparam logic [CRL_AW-1:0] CRL_A_DL_ID = 4'h7;
  localparam logic [CRL_AW-1:0] CRL_A_DL_ATTR = 4'h8;
  localparam logic [CRL_AW-1:0] CRL_A_DL_DONE = 4'h9;
  localparam logic [CRL_AW-1:0] CRL_A_STATUS = 4'hA;
  localparam logic [CRL_AW-1:0] CRL_A_EVENT = 4'hB;
  // Control register bits
  localparam int CRL_C_ON_DOOR = 0;
  localparam int CRL_C_OPEN_TIME = 1;
  localparam int CRL_C_ZONE_EN = 2;
  localparam int CRL_C_OFFLINE_EN = 3;
  localparam int CRL_C_OPEN_ZONE = 4;
  localparam int CRL_C_IN2_DIS = 5;
  localparam int CRL_C_IN2_POL = 6;
  localparam int CRL_C_W = 7;
  // Download attribute bits
  localparam int CRL_T_EXP_EN = 16;
  localparam int CRL_T_ALARM = 17;
  localparam int CRL_T_SCHED = 18;
  localparam int CRL_T_VALID = 19;
  localparam int CRL_EV_VALID = 31;
  localparam logic [CRL_CODE_W-1:0] CRL_EV_GRANTED = 4'h1;
  localparam logic [CRL_CODE_W-1:0] CRL_EV_INVALID = 4'h2;
  localparam logic [CRL_CODE_W-1:0] CRL_EV_ID_ALARM = 4'h3;
  localparam logic [CRL_CODE_W-1:0] CRL_EV_TIME_LOCK = 4'h4;
  localparam logic [CRL_CODE_W-1:0] CRL_EV_ZONE_LOCK = 4'h5;
  localparam logic [CRL_CODE_W-1:0] CRL_EV_REFUSED = 4'h6;
  localparam logic [CRL_CODE_W-1:0] CRL_EV_DIS_ON = 4'h7;
  localparam logic [CRL_CODE_W-1:0] CRL_EV_DIS_OFF = 4'h8;
  localparam logic [CRL_CODE_W-1:0] CRL_EV_REMOTE_REF = 4'h9;
  localparam logic [CRL_CODE_W-1:0] CRL_EV_ERASED = 4'hA;
  typedef struct packed {
    logic valid;
    logic sched;
    logic alarm;
    logic exp_en;
    logic expired;
    logic zone;
    logic [CRL_TMR_W-1:0] tmr;
    logic [CRL_DATE_W-1:0] exp;
    logic [CRL_ID_W-1:0] id;
  } crl_entry_t;
  typedef enum logic [1:0] {CRL_M_NORMAL, CRL_M_INS, CRL_M_DEL} crl_mode_t;
endpackage : crl_pkg

// ### logic/crl_log_if.sv
// Purpose: Carries archive pushes and pops between the rights logic and the archive
// Assumes: One push and one pop at most per clock
// Notes: Head word is valid only while empty is low
`timescale 1ns/100ps
interface crl_log_if;
  import crl_pkg::*;
  logic push;
  logic [CRL_CODE_W-1:0] code;
  logic [CRL_IDX_W-1:0] idx;
  logic pop;
  logic [CRL_CODE_W+CRL_IDX_W-1:0] head;
  logic empty;
  logic full;
  modport src (output push, code, idx, pop, input head, empty, full);
  modport sink (input push, code, idx, pop, output head, empty, full);
endinterface : crl_log_if

// ### logic/crl_in_sync.sv
// Purpose: Brings a pin into the clock domain
// Assumes: Pin may change at any time
// Notes: Output follows once the second and third stages agree
`timescale 1ns/100ps
module crl_in_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic ff1, ff2, ff3;
  logic next_q;

  always_comb begin
    next_q = (ff2 == ff3) ? ff3 : q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ff1 <= 1'b0;
      ff2 <= 1'b0;
      ff3 <= 1'b0;
      q <= 1'b0;
    end else begin
      ff1 <= d;
      ff2 <= ff1;
      ff3 <= ff2;
      q <= next_q;
    end
  end
endmodule : crl_in_sync

// ### logic/crl_event_log.sv
// Purpose: Event archive kept until software reads it
// Assumes: Reader pops through the register port
// Notes: When full, new events are dropped; software must drain in time
`timescale 1ns/100ps
module crl_event_log import crl_pkg::*; #(
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  crl_log_if.sink lg
);
  localparam int PW = $clog2(DEPTH);
  logic [CRL_CODE_W+CRL_IDX_W-1:0] store [DEPTH];
  logic [PW-1:0] wp, rp, next_wp, next_rp;
  logic [PW:0] cnt, next_cnt;
  logic do_push, do_pop;

  assign lg.empty = (cnt == '0);
  assign lg.full = (cnt == (PW+1)'(DEPTH));
  assign lg.head = store[rp];
  assign do_push = lg.push && !lg.full;
  assign do_pop = lg.pop && !lg.empty;

  always_comb begin
    next_wp = do_push ? PW'((wp + 1'b1) % DEPTH) : wp;
    next_rp = do_pop ? PW'((rp + 1'b1) % DEPTH) : rp;
    next_cnt = cnt + (PW+1)'(do_push) - (PW+1)'(do_pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (do_push) begin
      store[wp] <= {lg.code, lg.idx};
    end
  end
endmodule : crl_event_log

// ### logic/crl_card_rights.sv
// Purpose: Card memory, programming cards, expiry, alarm flag, reuse lockout and disabling
// Assumes: Card reads and remote requests arrive as one-cycle pulses on CLOCK
// Notes: Schedule validity and online state come from outside as levels
`timescale 1ns/100ps
module crl_card_rights import crl_pkg::*; #(
  parameter int NCARD = 16,
  parameter int LOG_DEPTH = 32,
  parameter int unsigned TICK_CYCLES = CRL_CLK_HZ * CRL_SEC_S
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic [CRL_AW-1:0] ADDR,
  input wire logic [CRL_DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [CRL_DW-1:0] RDATA,
  input wire logic CARD_VALID,
  input wire logic [CRL_ID_W-1:0] CARD_ID,
  input wire logic REMOTE_ID_VALID,
  input wire logic [CRL_ID_W-1:0] REMOTE_ID,
  input wire logic REMOTE_OPEN,
  input wire logic SCHED_OK,
  input wire logic ONLINE,
  input wire logic DOOR_IN,
  input wire logic IN2,
  output logic DOOR_OPEN,
  output logic INVALID_ID,
  output logic LOCK_ALARM,
  output logic ALARM_OUT,
  output logic PROG_MODE
);
  localparam int IW = $clog2(NCARD);
  localparam logic [2:0] ERASE_LAST = 3'(CRL_ERASE_READS - 1);
  localparam logic [4:0] PROG_LAST = 5'(CRL_PROG_TIMEOUT_S - 1);

  crl_log_if lg ();

  logic door_s, in2_s, door_q, next_door_q;
  logic [31:0] tick_cnt, next_tick_cnt;
  logic [5:0] min_cnt, next_min_cnt;
  logic sec_tick, min_tick;
  crl_mode_t mode, next_mode;
  crl_entry_t mem [NCARD];
  crl_entry_t next_mem [NCARD];
  crl_entry_t e;
  logic [IW:0] next_pos, next_next_pos;
  logic [2:0] erase_cnt, next_erase_cnt;
  logic [4:0] prog_sec, next_prog_sec;
  logic [CRL_TMR_W-1:0] alarm_cnt, next_alarm_cnt;
  logic [CRL_C_W-1:0] ctrl, next_ctrl;
  logic [CRL_TMR_W-1:0] lock_init, next_lock_init, alarm_secs, next_alarm_secs;
  logic [CRL_DATE_W-1:0] date, next_date;
  logic [CRL_ID_W-1:0] ins_id, next_ins_id, del_id, next_del_id, dl_id, next_dl_id;
  logic [IW-1:0] dl_idx, next_dl_idx, sweep_idx, next_sweep_idx, pend_idx, next_pend_idx;
  logic sweep_busy, next_sweep_busy, pend_valid, next_pend_valid;
  logic dis_state, next_dis_state, dis_pend, next_dis_pend, rem_pend, next_rem_pend;
  logic [CRL_DW-1:0] next_rdata;
  logic next_door_open, next_invalid, next_lock_alarm;
  logic pres, from_card, is_ins, is_del, fhit, lock_on, open;
  logic [CRL_ID_W-1:0] pid;
  logic [IW-1:0] hit_idx;

  crl_in_sync u_door_sync (.clk(CLOCK), .rst_n(RESET_N), .d(DOOR_IN), .q(door_s));
  crl_in_sync u_in2_sync (.clk(CLOCK), .rst_n(RESET_N), .d(IN2), .q(in2_s));
  crl_event_log #(.DEPTH(LOG_DEPTH)) u_log (.clk(CLOCK), .rst_n(RESET_N), .lg(lg.sink));

  assign sec_tick = (tick_cnt == TICK_CYCLES - 1);
  assign min_tick = sec_tick && (min_cnt == 6'(CRL_SEC_PER_MIN - 1));
  assign ALARM_OUT = (alarm_cnt != '0);
  assign PROG_MODE = (mode != CRL_M_NORMAL);
  assign pres = CARD_VALID || REMOTE_ID_VALID;
  assign from_card = CARD_VALID;
  assign pid = CARD_VALID ? CARD_ID : REMOTE_ID;
  assign is_ins = CARD_VALID && (CARD_ID == ins_id);
  assign is_del = CARD_VALID && (CARD_ID == del_id);
  assign lg.pop = RD && (ADDR == CRL_A_EVENT);

  always_comb begin
    fhit = 1'b0;
    hit_idx = '0;
    for (int i = 0; i < NCARD; i++) begin
      if (!fhit && mem[i].valid && mem[i].id == pid) begin
        fhit = 1'b1;
        hit_idx = IW'(i);
      end
    end
  end

  always_comb begin
    next_tick_cnt = sec_tick ? '0 : tick_cnt + 32'h1;
    next_min_cnt = min_tick ? '0 : (sec_tick ? min_cnt + 6'h1 : min_cnt);
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      tick_cnt <= '0;
      min_cnt <= '0;
    end else begin
      tick_cnt <= next_tick_cnt;
      min_cnt <= next_min_cnt;
    end
  end

  always_comb begin
    next_mem = mem;
    next_mode = mode;
    next_next_pos = next_pos;
    next_erase_cnt = erase_cnt;
    next_prog_sec = prog_sec;
    next_alarm_cnt = (sec_tick && alarm_cnt != '0) ? alarm_cnt - 1'b1 : alarm_cnt;
    next_ctrl = ctrl;
    next_lock_init = lock_init;
    next_alarm_secs = alarm_secs;
    next_date = date;
    next_ins_id = ins_id;
    next_del_id = del_id;
    next_dl_id = dl_id;
    next_dl_idx = dl_idx;
    next_sweep_busy = sweep_busy;
    next_sweep_idx = sweep_idx;
    next_pend_valid = pend_valid;
    next_pend_idx = pend_idx;
    next_door_q = door_s;
    next_dis_state = ctrl[CRL_C_IN2_DIS] && (in2_s == ctrl[CRL_C_IN2_POL]);
    next_dis_pend = dis_pend || (next_dis_state != dis_state);
    next_rem_pend = rem_pend;
    next_rdata = '0;
    next_door_open = 1'b0;
    next_invalid = 1'b0;
    next_lock_alarm = 1'b0;
    lg.push = 1'b0;
    lg.code = CRL_EV_GRANTED;
    lg.idx = '0;
    e = mem[hit_idx];
    lock_on = 1'b0;
    open = 1'b0;
    // Minute tick runs every lockout timer down
    if (min_tick) begin
      for (int i = 0; i < NCARD; i++) begin
        if (mem[i].tmr != '0) begin
          next_mem[i].tmr = mem[i].tmr - 1'b1;
        end
      end
    end
    // One entry per cycle keeps the comparator count at one
    if (sweep_busy) begin
      next_mem[sweep_idx].expired = mem[sweep_idx].exp_en && (date >= mem[sweep_idx].exp);
      next_sweep_busy = (sweep_idx != IW'(NCARD - 1));
      next_sweep_idx = sweep_idx + 1'b1;
    end
    // Deferred lockout flags land when the door actually opens
    if (pend_valid && door_s && !door_q) begin
      next_mem[pend_idx].tmr = lock_init;
      next_mem[pend_idx].zone = ctrl[CRL_C_ZONE_EN];
      next_pend_valid = 1'b0;
    end
    if (mode != CRL_M_NORMAL && sec_tick) begin
      next_prog_sec = prog_sec + 1'b1;
      if (prog_sec == PROG_LAST) begin
        next_mode = CRL_M_NORMAL;
      end
    end
    case (mode)
      CRL_M_NORMAL: begin
        if (is_ins) begin
          next_mode = CRL_M_INS;
          next_prog_sec = '0;
        end else if (is_del) begin
          next_mode = CRL_M_DEL;
          next_prog_sec = '0;
          next_erase_cnt = '0;
        end else if (pres) begin
          lg.push = 1'b1;
          lg.idx = CRL_IDX_W'(hit_idx);
          if (!fhit || e.expired || (e.sched && !SCHED_OK)) begin
            next_invalid = 1'b1;
            lg.code = CRL_EV_INVALID;
          end else begin
            lock_on = e.sched && (ONLINE || ctrl[CRL_C_OFFLINE_EN]);
            if (e.alarm) begin
              next_alarm_cnt = alarm_secs;
            end
            if (e.sched && dis_state) begin
              lg.code = CRL_EV_REFUSED;
            end else if (lock_on && e.tmr != '0) begin
              lg.code = CRL_EV_TIME_LOCK;
              next_lock_alarm = 1'b1;
              open = ctrl[CRL_C_OPEN_TIME];
            end else if (lock_on && ctrl[CRL_C_ZONE_EN] && e.zone) begin
              lg.code = CRL_EV_ZONE_LOCK;
              next_lock_alarm = 1'b1;
              open = ctrl[CRL_C_OPEN_ZONE];
            end else begin
              lg.code = e.alarm ? CRL_EV_ID_ALARM : CRL_EV_GRANTED;
              open = 1'b1;
            end
            next_door_open = open;
            if (open && lock_on) begin
              if (ctrl[CRL_C_ON_DOOR]) begin
                next_pend_valid = 1'b1;
                next_pend_idx = hit_idx;
              end else begin
                next_mem[hit_idx].tmr = lock_init;
                next_mem[hit_idx].zone = ctrl[CRL_C_ZONE_EN];
              end
            end
          end
        end
      end
      CRL_M_INS: begin
        if (is_ins) begin
          next_prog_sec = '0;
        end else if (is_del) begin
          next_mode = CRL_M_DEL;
          next_prog_sec = '0;
          next_erase_cnt = '0;
        end else if (from_card) begin
          next_prog_sec = '0;
          if (fhit) begin
            next_mem[hit_idx].tmr = '0;
            next_mem[hit_idx].zone = 1'b0;
          end else if (next_pos < (IW+1)'(NCARD)) begin
            next_mem[next_pos[IW-1:0]] = '{valid: 1'b1, id: CARD_ID, default: '0};
            next_next_pos = next_pos + 1'b1;
          end
        end
      end
      default: begin
        if (is_del) begin
          next_prog_sec = '0;
          if (erase_cnt == ERASE_LAST) begin
            for (int i = 0; i < NCARD; i++) begin
              next_mem[i] = '0;
            end
            next_next_pos = '0;
            next_pend_valid = 1'b0;
            next_mode = CRL_M_NORMAL;
            lg.push = 1'b1;
            lg.code = CRL_EV_ERASED;
          end else begin
            next_erase_cnt = erase_cnt + 1'b1;
          end
        end else if (is_ins) begin
          next_mode = CRL_M_INS;
          next_prog_sec = '0;
          next_erase_cnt = '0;
        end else if (from_card) begin
          next_prog_sec = '0;
          next_erase_cnt = '0;
          if (fhit) begin
            next_mem[hit_idx].valid = 1'b0;
          end
        end
      end
    endcase
    if (REMOTE_OPEN) begin
      if (dis_state) begin
        next_rem_pend = 1'b1;
      end else begin
        next_door_open = 1'b1;
      end
    end
    // Archive takes one entry a cycle; side events wait their turn
    if (!lg.push && rem_pend) begin
      lg.push = 1'b1;
      lg.code = CRL_EV_REMOTE_REF;
      next_rem_pend = REMOTE_OPEN && dis_state;
    end else if (!lg.push && dis_pend) begin
      lg.push = 1'b1;
      lg.code = dis_state ? CRL_EV_DIS_ON : CRL_EV_DIS_OFF;
      next_dis_pend = (next_dis_state != dis_state);
    end
    if (WR) begin
      if (ADDR == CRL_A_CTRL) begin
        next_ctrl = WDATA[CRL_C_W-1:0];
      end else if (ADDR == CRL_A_LOCK_INIT) begin
        next_lock_init = WDATA[CRL_TMR_W-1:0];
      end else if (ADDR == CRL_A_ALARM_SECS) begin
        next_alarm_secs = WDATA[CRL_TMR_W-1:0];
      end else if (ADDR == CRL_A_DATE) begin
        next_date = WDATA[CRL_DATE_W-1:0];
        if (WDATA[CRL_DATE_W-1:0] != date) begin
          next_sweep_busy = 1'b1;
          next_sweep_idx = '0;
        end
      end else if (ADDR == CRL_A_INS_CARD) begin
        next_ins_id = WDATA[CRL_ID_W-1:0];
      end else if (ADDR == CRL_A_DEL_CARD) begin
        next_del_id = WDATA[CRL_ID_W-1:0];
      end else if (ADDR == CRL_A_DL_INDEX) begin
        next_dl_idx = WDATA[IW-1:0];
      end else if (ADDR == CRL_A_DL_ID) begin
        next_dl_id = WDATA[CRL_ID_W-1:0];
      end else if (ADDR == CRL_A_DL_ATTR) begin
        next_mem[dl_idx] = '{valid: WDATA[CRL_T_VALID], sched: WDATA[CRL_T_SCHED], alarm: WDATA[CRL_T_ALARM],
                             exp_en: WDATA[CRL_T_EXP_EN], exp: WDATA[CRL_DATE_W-1:0], id: dl_id, default: '0};
      end else if (ADDR == CRL_A_DL_DONE) begin
        for (int i = 0; i < NCARD; i++) begin
          next_mem[i].tmr = '0;
          next_mem[i].zone = 1'b0;
        end
        next_pend_valid = 1'b0;
        next_sweep_busy = 1'b1;
        next_sweep_idx = '0;
      end
    end
    if (RD) begin
      if (ADDR == CRL_A_CTRL) begin
        next_rdata = CRL_DW'(ctrl);
      end else if (ADDR == CRL_A_LOCK_INIT) begin
        next_rdata = CRL_DW'(lock_init);
      end else if (ADDR == CRL_A_ALARM_SECS) begin
        next_rdata = CRL_DW'(alarm_secs);
      end else if (ADDR == CRL_A_DATE) begin
        next_rdata = CRL_DW'(date);
      end else if (ADDR == CRL_A_INS_CARD) begin
        next_rdata = CRL_DW'(ins_id);
      end else if (ADDR == CRL_A_DEL_CARD) begin
        next_rdata = CRL_DW'(del_id);
      end else if (ADDR == CRL_A_DL_INDEX) begin
        next_rdata = CRL_DW'(dl_idx);
      end else if (ADDR == CRL_A_DL_ID) begin
        next_rdata = CRL_DW'(dl_id);
      end else if (ADDR == CRL_A_STATUS) begin
        next_rdata = {16'h0, 8'(next_pos), 2'h0, lg.full, sweep_busy, ALARM_OUT, dis_state, mode};
      end else if (ADDR == CRL_A_EVENT) begin
        next_rdata = {!lg.empty, 19'h0, lg.head};
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < NCARD; i++) begin
        mem[i] <= '0;
      end
      mode <= CRL_M_NORMAL;
      next_pos <= '0;
      erase_cnt <= '0;
      prog_sec <= '0;
      alarm_cnt <= '0;
      ctrl <= '0;
      lock_init <= '0;
      alarm_secs <= '0;
      date <= '0;
      ins_id <= '0;
      del_id <= '0;
      dl_id <= '0;
      dl_idx <= '0;
      sweep_busy <= 1'b0;
      sweep_idx <= '0;
      pend_valid <= 1'b0;
      pend_idx <= '0;
      door_q <= 1'b0;
      dis_state <= 1'b0;
      dis_pend <= 1'b0;
      rem_pend <= 1'b0;
      RDATA <= '0;
      DOOR_OPEN <= 1'b0;
      INVALID_ID <= 1'b0;
      LOCK_ALARM <= 1'b0;
    end else begin
      mem <= next_mem;
      mode <= next_mode;
      next_pos <= next_next_pos;
      erase_cnt <= next_erase_cnt;
      prog_sec <= next_prog_sec;
      alarm_cnt <= next_alarm_cnt;
      ctrl <= next_ctrl;
      lock_init <= next_lock_init;
      alarm_secs <= next_alarm_secs;
      date <= next_date;
      ins_id <= next_ins_id;
      del_id <= next_del_id;
      dl_id <= next_dl_id;
      dl_idx <= next_dl_idx;
      sweep_busy <= next_sweep_busy;
      sweep_idx <= next_sweep_idx;
      pend_valid <= next_pend_valid;
      pend_idx <= next_pend_idx;
      door_q <= next_door_q;
      dis_state <= next_dis_state;
      dis_pend <= next_dis_pend;
      rem_pend <= next_rem_pend;
      RDATA <= next_rdata;
      DOOR_OPEN <= next_door_open;
      INVALID_ID <= next_invalid;
      LOCK_ALARM <= next_lock_alarm;
    end
  end
endmodule : crl_card_rights

// ### testbench/crl_door_model.sv
// Purpose: Door leaf and contact on the far side of the reader
// Assumes: A person walks through after each door open pulse
// Notes: Contact reads open for OPEN_CYC cycles, then closed again
`timescale 1ns/100ps
module crl_door_model #(
  parameter int OPEN_CYC = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic door_open,
  output logic door_in
);
  int cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt <= 0;
    else if (door_open) cnt <= OPEN_CYC;
    else if (cnt != 0) cnt <= cnt - 1;
  end
  // Contact disconnected only while the leaf stands open
  assign door_in = (cnt != 0);
endmodule : crl_door_model

// ### testbench/crl_card_rights_assertions.sv
// Purpose: Port-level checks of the card rights block
// Assumes: Programming codes and control bits shadowed from register writes
// Notes: Writes to the control word must not share an edge with a card read
`timescale 1ns/100ps
module crl_checker import crl_pkg::*; #(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic [CRL_AW-1:0] ADDR,
  input wire logic [CRL_DW-1:0] WDATA,
  input wire logic WR,
  input wire logic CARD_VALID,
  input wire logic [CRL_ID_W-1:0] CARD_ID,
  input wire logic REMOTE_ID_VALID,
  input wire logic REMOTE_OPEN,
  input wire logic ONLINE,
  input wire logic DOOR_OPEN,
  input wire logic INVALID_ID,
  input wire logic LOCK_ALARM,
  input wire logic ALARM_OUT,
  input wire logic PROG_MODE
);
  localparam int unsigned IDLE_MAX = 16 * TICK_CYCLES + 4;
  logic [CRL_ID_W-1:0] ins_code, del_code;
  logic [CRL_C_W-1:0] ctrl;
  logic read_q, cause_q;
  int unsigned idle;
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      ins_code <= '0;
      del_code <= '0;
      ctrl <= '0;
      read_q <= 1'b0;
      cause_q <= 1'b0;
      idle <= 0;
    end else begin
      if (WR && ADDR == CRL_A_INS_CARD) ins_code <= WDATA;
      if (WR && ADDR == CRL_A_DEL_CARD) del_code <= WDATA;
      if (WR && ADDR == CRL_A_CTRL) ctrl <= WDATA[CRL_C_W-1:0];
      read_q <= CARD_VALID || REMOTE_ID_VALID;
      cause_q <= CARD_VALID || REMOTE_ID_VALID || REMOTE_OPEN;
      idle <= (!PROG_MODE || CARD_VALID) ? 0 : idle + 1;
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  sequence read_s;
    CARD_VALID || REMOTE_ID_VALID;
  endsequence
  // Zero codes are skipped by this check; the block itself still counts them as programming cards
  sequence prog_card_s;
    CARD_VALID && !PROG_MODE && ((CARD_ID == ins_code && ins_code != '0) || (CARD_ID == del_code && del_code != '0));
  endsequence
  prog_entry_a: assert property (prog_card_s |=> PROG_MODE)
    else $error("programming card left mode unchanged");
  prog_timeout_a: assert property (idle <= IDLE_MAX)
    else $error("programming mode outlived its idle time");
  lock_cause_a: assert property (LOCK_ALARM |-> read_q)
    else $error("lockout alarm without a read");
  offline_quiet_a: assert property (LOCK_ALARM |-> $past(ONLINE) || ctrl[CRL_C_OFFLINE_EN])
    else $error("lockout alarm while offline use is off");
  lock_no_open_a: assert property (LOCK_ALARM && !ctrl[CRL_C_OPEN_TIME] && !ctrl[CRL_C_OPEN_ZONE] |-> !DOOR_OPEN)
    else $error("door opened after lockout alarm");
  alarm_cause_a: assert property ($rose(ALARM_OUT) |-> read_q)
    else $error("alarm output rose without a read");
  open_cause_a: assert property (DOOR_OPEN |-> cause_q)
    else $error("door open without a request");
  invalid_no_open_a: assert property (read_s ##1 INVALID_ID |-> !DOOR_OPEN)
    else $error("invalid card opened the door");
endmodule : crl_checker

// ### testbench/crl_card_rights_tb_top.sv
// Purpose: Directed bench for the card rights block
// Assumes: One second shortened to TICK_CYCLES clocks
// Notes: Card results packed as {invalid, lock alarm, door open}
`timescale 1ns/100ps
module crl_card_rights_tb_top;
  import crl_pkg::*;
  localparam int unsigned TICK = 10;
  logic clock = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0, card_valid = 1'b0, remote_open = 1'b0;
  logic sched_ok = 1'b1, online = 1'b1, in2 = 1'b0, rid_v = 1'b0;
  logic [CRL_AW-1:0] addr = '0;
  logic [CRL_DW-1:0] wdata = '0, rdat;
  logic [CRL_ID_W-1:0] card_id = '0;
  logic [CRL_DW-1:0] rdata;
  logic door_open, invalid_id, lock_alarm, alarm_out, prog_mode, door_in;
  logic [2:0] res;
  int miscompares = 0, tests_run = 0, cyc = 0;
  always #4 clock = ~clock;
  crl_card_rights #(.TICK_CYCLES(TICK)) i_dut (.CLOCK(clock), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .CARD_VALID(card_valid), .CARD_ID(card_id), .REMOTE_ID_VALID(rid_v),
    .REMOTE_ID(card_id), .REMOTE_OPEN(remote_open), .SCHED_OK(sched_ok), .ONLINE(online),
    .DOOR_IN(door_in), .IN2(in2), .DOOR_OPEN(door_open), .INVALID_ID(invalid_id), .LOCK_ALARM(lock_alarm),
    .ALARM_OUT(alarm_out), .PROG_MODE(prog_mode));
  crl_door_model i_door (.clk(clock), .rst_n(reset_n), .door_open(door_open), .door_in(door_in));
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic reg_wr(input logic [CRL_AW-1:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [CRL_AW-1:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 rdat = rdata;
  endtask : reg_rd
  task automatic card(input logic [31:0] id, input logic [1:0] how = 2'h0);
    @(posedge clock);
    card_id <= id;
    if (how == 2'h1) remote_open <= 1'b1;
    else if (how == 2'h2) rid_v <= 1'b1;
    else card_valid <= 1'b1;
    @(posedge clock);
    card_valid <= 1'b0;
    remote_open <= 1'b0;
    rid_v <= 1'b0;
    #1 res = {invalid_id, lock_alarm, door_open};
  endtask : card
  task automatic dl(input logic [31:0] idx, input logic [31:0] id, input logic [31:0] attr);
    reg_wr(CRL_A_DL_INDEX, idx);
    reg_wr(CRL_A_DL_ID, id);
    reg_wr(CRL_A_DL_ATTR, attr);
  endtask : dl
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    reg_wr(CRL_A_INS_CARD, 32'hA);
    reg_wr(CRL_A_DEL_CARD, 32'hD);
    reg_wr(CRL_A_LOCK_INIT, 32'h1);
    reg_wr(CRL_A_ALARM_SECS, 32'h2);
    reg_wr(CRL_A_CTRL, 32'h4);
    dl(32'h8, 32'h21, 32'h000C_0000);
    dl(32'h9, 32'h22, 32'h0009_0005);
    dl(32'hA, 32'h23, 32'h000A_0000);
    dl(32'hB, 32'h24, 32'h0008_0000);
    reg_wr(CRL_A_DL_DONE, 32'h1);
    repeat (20) @(posedge clock);
    reg_rd(4'hF);
    chk("unmapped", rdat, 32'h0);
    card(32'h21);
    chk("pass", res, 3'h1);
    card(32'h21);
    chk("reread", res, 3'h2);
    reg_wr(CRL_A_CTRL, 32'h16);
    card(32'h21);
    chk("open after lock", res, 3'h3);
    reg_wr(CRL_A_DL_DONE, 32'h1);
    repeat (20) @(posedge clock);
    card(32'h21);
    chk("flags cleared", res, 3'h1);
    online <= 1'b0;
    reg_wr(CRL_A_CTRL, 32'h4);
    card(32'h21);
    chk("offline", res, 3'h1);
    online <= 1'b1;
    card(32'h24);
    card(32'h24);
    chk("always user", res, 3'h1);
    reg_wr(CRL_A_DATE, 32'h5);
    repeat (20) @(posedge clock);
    card(32'h22);
    chk("expired", res, 3'h4);
    card(32'h23);
    repeat (3) @(posedge clock);
    chk("alarm on", alarm_out, 32'h1);
    repeat (25) @(posedge clock);
    chk("alarm off", alarm_out, 32'h0);
    reg_wr(CRL_A_CTRL, 32'h5);
    reg_wr(CRL_A_DL_DONE, 32'h1);
    card(32'h21);
    card(32'h21);
    chk("door pending", res, 3'h1);
    repeat (12) @(posedge clock);
    card(32'h21);
    chk("door opened", res, 3'h2);
    reg_wr(CRL_A_DL_DONE, 32'h1);
    repeat (40) reg_rd(CRL_A_EVENT);
    reg_wr(CRL_A_CTRL, 32'h64);
    in2 <= 1'b1;
    repeat (8) @(posedge clock);
    reg_rd(CRL_A_STATUS);
    chk("disabled", rdat[2], 32'h1);
    reg_rd(CRL_A_EVENT);
    chk("event on", {rdat[31], rdat[11:8]}, 32'h17);
    card(32'h21);
    chk("sched refused", res[0], 32'h0);
    reg_rd(CRL_A_EVENT);
    chk("event refused", {rdat[31], rdat[11:8]}, 32'h16);
    card(32'h24);
    chk("always open", res[0], 32'h1);
    card(32'h0, 2'h1);
    chk("remote refused", res[0], 32'h0);
    card(32'h21, 2'h2);
    chk("remote id", res[0], 32'h0);
    in2 <= 1'b0;
    repeat (8) @(posedge clock);
    card(32'hA);
    card(32'h31);
    card(32'h32);
    reg_rd(CRL_A_STATUS);
    chk("insert", {rdat[15:8], rdat[1:0]}, 32'h9);
    repeat (130) @(posedge clock);
    chk("still prog", prog_mode, 32'h1);
    repeat (40) @(posedge clock);
    chk("timed out", prog_mode, 32'h0);
    repeat (5) card(32'hD);
    card(32'h31);
    chk("count dropped", prog_mode, 32'h1);
    repeat (5) card(32'hD);
    reg_rd(CRL_A_STATUS);
    chk("erased", {rdat[15:8], rdat[1:0]}, 32'h0);
    card(32'h32);
    chk("gone", res, 3'h4);
    tally_and_finish();
  end
endmodule : crl_card_rights_tb_top
bind crl_card_rights crl_checker #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.CLOCK(CLOCK), .RESET_N(RESET_N),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .CARD_VALID(CARD_VALID), .CARD_ID(CARD_ID),
  .REMOTE_ID_VALID(REMOTE_ID_VALID), .REMOTE_OPEN(REMOTE_OPEN), .ONLINE(ONLINE), .DOOR_OPEN(DOOR_OPEN),
  .INVALID_ID(INVALID_ID), .LOCK_ALARM(LOCK_ALARM), .ALARM_OUT(ALARM_OUT), .PROG_MODE(PROG_MODE));
